// file: hst_selftest.sv
// Power-on self-test sequencer and output drivers of the magnetic switch.
// Assumes RST stands for supply power-up: its release is the supply reaching 90 percent.
// Line levels and the field comparator results arrive asynchronously.
import hst_pkg::*;

module hst_selftest
#(
    parameter int RLS_MIN = hst_pkg::RLS_MIN_CYC,
    parameter int FALL_DLY = hst_pkg::FALL_DLY_CYC,
    parameter int RISE_DLY = hst_pkg::RISE_DLY_CYC,
    parameter int LIVE_DLY = hst_pkg::LIVE_DLY_CYC
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic OUT_LINE_IN,
    input wire logic ABOVE_OPERATE,
    input wire logic BELOW_RELEASE_THRESHOLD,
    output logic FIRST_SWITCH_OUTPUT_OE_N,
    output logic SECOND_SWITCH_OUTPUT_OE_N,
    output logic FIRST_SWITCH_OUTPUT_O,
    output logic SECOND_SWITCH_OUTPUT_O,
    output logic DIAG_ACTIVE
);
    import hst_pkg::*;

    hst_sync_if sio ();
    hst_state_t state_reg;
    hst_state_t state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic magnet_reg;
    logic magnet_next;
    logic oe_n_reg;
    logic drive_next;
    logic diag_reg;
    logic diag_next;
    logic line_low;
    logic field_on;
    logic field_off;
    logic cnt_done_rls;
    logic cnt_done_fall;
    logic cnt_done_rise;
    logic cnt_done_live;
    logic sync_full;
    logic [CNT_W-1:0] cnt_inc;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    assign sio.raw = {OUT_LINE_IN, ABOVE_OPERATE, BELOW_RELEASE_THRESHOLD};

    hst_sync u_sync
    (
        .CLK(CLK),
        .RST(RST),
        .sio(sio)
    );

    assign line_low = ~sio.synced[2];
    assign field_on = sio.synced[1];
    assign field_off = sio.synced[0];

    ////////////////////////////////////////////////////////////////////////
    // Counter compares; counter saturates so it never wraps
    assign cnt_inc = (cnt_reg == {CNT_W{1'b1}}) ? cnt_reg : cnt_reg + 12'h001;
    assign cnt_done_rls = (cnt_reg >= CNT_W'(RLS_MIN - 1));
    assign cnt_done_fall = (cnt_reg >= CNT_W'(FALL_DLY - 1));
    assign cnt_done_rise = (cnt_reg >= CNT_W'(RISE_DLY - 1));
    assign cnt_done_live = (cnt_reg >= CNT_W'(LIVE_DLY - 1));
    assign sync_full = (cnt_reg >= CNT_W'(SYNC_LAG_CYC)); // Synchroniser holds real pin levels

    ////////////////////////////////////////////////////////////////////////
    // Hysteresis latch: between thresholds the last decision is kept
    always_comb
    begin
        magnet_next = magnet_reg;
        if (field_on)
        begin
            magnet_next = 1'b1;
        end
        else if (field_off)
        begin
            magnet_next = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer; only the power-up path leads into the test states
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_inc;
        drive_next = 1'b0;
        diag_next = 1'b0;
        case (state_reg)
            HST_POWER_UP:
            begin
                // Line must already be low when supply settles; the synchroniser
                // comes out of reset showing high, so judge only once it has filled
                if (sync_full)
                begin
                    cnt_next = CNT_RST;
                    if (line_low)
                    begin
                        state_next = HST_HELD_LOW;
                        diag_next = 1'b1;
                    end
                    else
                    begin
                        state_next = HST_NORMAL;
                    end
                end
            end
            HST_HELD_LOW:
            begin
                diag_next = 1'b1;
                if (!line_low)
                begin
                    cnt_next = CNT_RST;
                    if (cnt_done_rls)
                    begin
                        state_next = HST_WAIT_FALL;
                    end
                    else
                    begin
                        state_next = HST_NORMAL;
                        diag_next = 1'b0;
                    end
                end
            end
            HST_WAIT_FALL:
            begin
                diag_next = 1'b1;
                if (cnt_done_fall)
                begin
                    cnt_next = CNT_RST;
                    drive_next = 1'b1;
                    state_next = HST_DRIVE_LOW;
                end
            end
            HST_DRIVE_LOW:
            begin
                diag_next = 1'b1;
                drive_next = 1'b1;
                if (cnt_done_rise)
                begin
                    cnt_next = CNT_RST;
                    drive_next = 1'b0;
                    state_next = HST_WAIT_LIVE;
                end
            end
            HST_WAIT_LIVE:
            begin
                diag_next = 1'b1;
                if (cnt_done_live)
                begin
                    diag_next = 1'b0;
                    drive_next = magnet_next;
                    state_next = HST_NORMAL;
                end
            end
            HST_NORMAL:
            begin
                // Stays here until the next power-up
                cnt_next = cnt_reg;
                drive_next = magnet_next;
            end
            default:
            begin
                state_next = HST_NORMAL;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers; reset models a fresh power-up
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            state_reg <= HST_POWER_UP;
            cnt_reg <= CNT_RST;
            magnet_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            diag_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            magnet_reg <= magnet_next;
            oe_n_reg <= ~drive_next; // Stored inverted so the pin comes straight from a flop
            diag_reg <= diag_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Open-drain outputs: enable low means pulling low; both outputs switch alike
    assign FIRST_SWITCH_OUTPUT_OE_N = oe_n_reg;
    assign SECOND_SWITCH_OUTPUT_OE_N = oe_n_reg;
    assign FIRST_SWITCH_OUTPUT_O = 1'b0;
    assign SECOND_SWITCH_OUTPUT_O = 1'b0;
    assign DIAG_ACTIVE = diag_reg;
endmodule

// file: hst_pkg.sv
// Package for the power-on self-test of the magnetic switch.
// Assumes a single 50 MHz clock; all times are converted to cycle counts here.
package hst_pkg;
    localparam int CLK_MHZ = 50;
    // Times in microseconds
    localparam int RLS_MIN_US = 20;
    localparam int FALL_DLY_US = 10;
    localparam int RISE_DLY_US = 10;
    localparam int LIVE_DLY_US = 30;
    // Cycle counts derived from the rate
    localparam int RLS_MIN_CYC = RLS_MIN_US * CLK_MHZ;
    localparam int FALL_DLY_CYC = FALL_DLY_US * CLK_MHZ;
    localparam int RISE_DLY_CYC = RISE_DLY_US * CLK_MHZ;
    localparam int LIVE_DLY_CYC = (LIVE_DLY_US - FALL_DLY_US - RISE_DLY_US) * CLK_MHZ;
    // Edges the pin synchroniser needs before the line level can be trusted
    localparam int SYNC_LAG_CYC = 2;
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] CNT_RST = 12'h000;

    typedef enum logic [2:0] {
        HST_POWER_UP = 3'b000,
        HST_HELD_LOW = 3'b001,
        HST_WAIT_FALL = 3'b010,
        HST_DRIVE_LOW = 3'b011,
        HST_WAIT_LIVE = 3'b100,
        HST_NORMAL = 3'b101
    } hst_state_t;
endpackage

// file: hst_sync_if.sv
// Carrier between the top module and its input synchroniser.
// Assumes both ends run on the same clock.
interface hst_sync_if;
    logic [2:0] raw;
    logic [2:0] synced;
    modport src (output raw, input synced);
    modport dst (input raw, output synced);
endinterface

// file: hst_sync.sv
// Two-flip-flop synchroniser for the pins that arrive from outside.
// Assumes the pins are asynchronous levels.
module hst_sync
(
    input wire logic CLK,
    input wire logic RST,
    hst_sync_if.dst sio
);
    logic [2:0] meta_reg;
    logic [2:0] sync_reg;

    ////////////////////////////////////////////////////////////////////////
    // First stage read only by the second
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            meta_reg <= 3'h7;
            sync_reg <= 3'h7;
        end
        else
        begin
            meta_reg <= sio.raw;
            sync_reg <= meta_reg;
        end
    end

    assign sio.synced = sync_reg;
endmodule

// file: hst_selftest_props.sv
// Assertions on the self-test sequencer's top-level ports.
// Assumes OUT_LINE_IN is the wired line formed by host and sensor.
module hst_selftest_props
#(
    parameter int FALL_DLY = 8,
    parameter int RISE_DLY = 8,
    parameter int LIVE_DLY = 8
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic OUT_LINE_IN,
    input wire logic ABOVE_OPERATE,
    input wire logic BELOW_RELEASE_THRESHOLD,
    input wire logic FIRST_SWITCH_OUTPUT_OE_N,
    input wire logic DIAG_ACTIVE
);
    timeunit 1ns;
    timeprecision 1ns;
    // Windows span half to one and a half the delay, plus sync lag
    localparam int F_LO = FALL_DLY / 2;
    localparam int F_HI = FALL_DLY * 3 / 2 + 2;
    // Same window counted from three cycles after release, once the sensor kept the test
    localparam int F_LO3 = F_LO - 3;
    localparam int F_HI3 = F_HI - 3;
    localparam int L_HI = LIVE_DLY * 3 / 2 + 2;
    wire logic oe = FIRST_SWITCH_OUTPUT_OE_N;
    wire logic dg = DIAG_ACTIVE;
    logic done_reg;
    logic high_reg;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////
    // Test already ended; line never low since supply good
    always_ff @(posedge CLK)
    begin
        done_reg <= !RST && (done_reg || $fell(dg));
        high_reg <= RST ? OUT_LINE_IN : high_reg && OUT_LINE_IN;
    end
    a_single_run: assert property (done_reg |-> !$rose(dg))
        else $error("self-test ran twice");
    a_skip_unheld: assert property (high_reg |-> !dg)
        else $error("self-test without held line");
    a_fall_window: assert property ($rose(OUT_LINE_IN) && $stable(oe) && !done_reg ##3 dg |-> ##[F_LO3:F_HI3] $fell(oe))
        else $error("operate pulse out of window");
    a_pulse_width: assert property ($fell(oe) && dg |-> !oe [*4] ##[1:RISE_DLY] oe)
        else $error("release edge out of window");
    a_live_after: assert property ($rose(oe) && dg |-> ##[1:L_HI] !dg)
        else $error("normal mode late");
    a_operate_on: assert property ((!dg && ABOVE_OPERATE) [*5] |-> !oe)
        else $error("output off above operate");
    a_release_off: assert property ((!dg && BELOW_RELEASE_THRESHOLD) [*5] |-> oe)
        else $error("output on below release");
    c_pulse: cover property ($fell(oe) && dg);
    c_end: cover property ($fell(dg));
    c_skip: cover property (high_reg [*8]);
endmodule
bind hst_selftest hst_selftest_props #(.FALL_DLY(FALL_DLY), .RISE_DLY(RISE_DLY), .LIVE_DLY(LIVE_DLY)) u_props
(
    .CLK(CLK),
    .RST(RST),
    .OUT_LINE_IN(OUT_LINE_IN),
    .ABOVE_OPERATE(ABOVE_OPERATE),
    .BELOW_RELEASE_THRESHOLD(BELOW_RELEASE_THRESHOLD),
    .FIRST_SWITCH_OUTPUT_OE_N(FIRST_SWITCH_OUTPUT_OE_N),
    .DIAG_ACTIVE(DIAG_ACTIVE)
);

// file: hst_host_model.sv
// Host model: holds or frees the sensor line and times the test edges.
// Assumes a pull-up on the line and delays shortened to 8 cycles.
module hst_host_model
(
    input wire logic CLK,
    input wire logic hold_low,
    input wire logic oe_n,
    output logic line,
    output logic diag_ok
);
    timeunit 1ns;
    timeprecision 1ns;
    int t_reg;
    int fall_reg;
    int rise_reg;
    // Either party pulls low, the pull-up wins otherwise
    assign line = !hold_low && oe_n;
    // Missing or stray edge leaves the verdict false
    assign diag_ok = fall_reg inside {[4:14]} && (rise_reg - fall_reg) inside {[4:12]};
    // Edge times counted from the host release
    always @(posedge CLK)
    begin
        t_reg <= hold_low ? 0 : t_reg + 1;
        fall_reg <= hold_low ? 0 : (fall_reg == 0 && !oe_n) ? t_reg : fall_reg;
        rise_reg <= hold_low ? 0 : (fall_reg != 0 && rise_reg == 0 && oe_n) ? t_reg : rise_reg;
    end
endmodule

// file: tb_hall_switch_power_on_selftest.sv
// Self-checking bench for the power-on self-test of the magnetic switch.
// Assumes all delays shortened to P cycles; the host model times the edges.
module tb_hall_switch_power_on_selftest;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int P = 8;
    logic CLK = 1'h0;
    logic RST = 1'h1;
    logic hold = 1'h1;
    logic above = 1'h0;
    logic below = 1'h1;
    logic oe1;
    logic oe2;
    logic o1;
    logic o2;
    logic line;
    logic ok;
    logic diag;
    int err_count = 0;
    int n_compared = 0;
    `define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
        $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
    hst_selftest #(.RLS_MIN(P), .FALL_DLY(P), .RISE_DLY(P), .LIVE_DLY(P)) DUT
    (
        .CLK(CLK), .RST(RST), .OUT_LINE_IN(line), .ABOVE_OPERATE(above), .BELOW_RELEASE_THRESHOLD(below),
        .FIRST_SWITCH_OUTPUT_OE_N(oe1), .SECOND_SWITCH_OUTPUT_OE_N(oe2), .FIRST_SWITCH_OUTPUT_O(o1),
        .SECOND_SWITCH_OUTPUT_O(o2), .DIAG_ACTIVE(diag)
    );
    hst_host_model host (.CLK(CLK), .hold_low(hold), .oe_n(oe1), .line(line), .diag_ok(ok));
    always #10 CLK = ~CLK;
    ////////////////////////////////////////
    // Supply cycle, line held or not, freed gap cycles after reset release
    task automatic power_up(input logic low, input int gap);
        @(posedge CLK);
        hold <= low;
        RST <= 1'h1;
        repeat (16) @(posedge CLK);
        RST <= 1'h0;
        repeat (gap) @(posedge CLK);
        hold <= 1'h0;
    endtask
    // Latest live output is 45 us after release, scaled
    task automatic t_selftest;
        power_up(1'h1, P + 4);
        repeat (P * 9 / 2) @(posedge CLK);
        `CHK("diag_active", 1'h0, diag)
        `CHK("diag_edges", 1'h1, ok)
    endtask
    task automatic t_field;
        above <= 1'h1;
        below <= 1'h0;
        repeat (6) @(posedge CLK);
        `CHK("on_above", 2'h0, {oe1, oe2})
        `CHK("drive_level", 2'h0, {o1, o2})
        above <= 1'h0;
        below <= 1'h1;
        repeat (6) @(posedge CLK);
        `CHK("off_below", 2'h3, {oe1, oe2})
    endtask
    // Holding the line in mid-run must not start a second test
    task automatic t_once;
        hold <= 1'h1;
        repeat (2 * P) @(posedge CLK);
        hold <= 1'h0;
        repeat (P * 9 / 2) @(posedge CLK);
        `CHK("rerun_diag", 1'h0, diag)
        `CHK("rerun_edges", 1'h0, ok)
    endtask
    task automatic t_skip;
        power_up(1'h0, P + 4);
        repeat (P * 9 / 2) @(posedge CLK);
        `CHK("skip_diag", 1'h0, diag)
        `CHK("skip_edges", 1'h0, ok)
    endtask
    // Line held through power-up but freed well before the minimum wait
    task automatic t_early;
        power_up(1'h1, 2);
        repeat (5) @(posedge CLK);
        `CHK("early_diag", 1'h0, diag)
        repeat (P * 4) @(posedge CLK);
        `CHK("early_edges", 1'h0, ok)
        `CHK("early_idle", 2'h3, {oe1, oe2})
    endtask
    task automatic finish_test;
        if (err_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        t_selftest();
        t_field();
        t_once();
        t_skip();
        t_field();
        t_early();
        finish_test();
    end
endmodule
